// ==== core/adcsp_pkg.sv ====
// Constants, field layout and state codes of the converter mode control and
// serial port. Assumes a 20 MHz system clock feeding the core.
package adcsp_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int SYS_CLK_HZ    = 20_000_000;
	localparam int TIMEOUT_MS    = 28;
	localparam int TIMEOUT_CYC   = TIMEOUT_MS * (SYS_CLK_HZ / 1000);
	localparam int RDY_LEAD_US   = 8;
	localparam int RDY_LEAD_CYC  = RDY_LEAD_US * (SYS_CLK_HZ / 1_000_000);
	localparam int TO_W          = 20;
	localparam int CONV_W        = 18;

	// ------------------------------------------------------------------
	// Data rates in samples per second, by rate field code
	// ------------------------------------------------------------------
	localparam int SPS_R0        = 128;
	localparam int SPS_R1        = 250;
	localparam int SPS_R2        = 490;
	localparam int SPS_R3        = 920;
	localparam int SPS_R4        = 1600;
	localparam int SPS_R5        = 2400;
	localparam int SPS_R6        = 3300;

	// ------------------------------------------------------------------
	// Configuration word layout
	// ------------------------------------------------------------------
	localparam int CFG_SS_BIT    = 15;
	localparam int CFG_MUX_LSB   = 12;
	localparam int CFG_PGA_LSB   = 9;
	localparam int CFG_MODE_BIT  = 8;
	localparam int CFG_DR_LSB    = 5;
	localparam int CFG_TS_BIT    = 4;
	localparam int CFG_PU_BIT    = 3;
	localparam int CFG_NOP_LSB   = 1;
	localparam int FIELD3_W      = 3;
	localparam int WORD_W        = 16;
	localparam int CYCLE_BITS    = 32;
	localparam int CNT_W         = 6;
	localparam int RES_W         = 12;
	localparam logic [15:0] CFG_RST    = 16'h058B;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [1:0]  NOP_VALID  = 2'h1;
	localparam logic        SS_READ    = 1'h0;
	localparam logic        RSV_READ   = 1'h1;
	localparam logic [3:0]  RES_PAD    = 4'h0;
	localparam logic [11:0] CLIP_POS   = 12'h7FF;
	localparam logic [11:0] CLIP_NEG   = 12'h800;

	// ------------------------------------------------------------------
	// Converter sequencing states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_DOWN   = 3'b001,
		ST_SINGLE = 3'b010,
		ST_CONT   = 3'b100
	} adcsp_conv_e;

endpackage

// ==== core/adcsp_core.sv ====
// Mode control, conversion sequencing and serial port of a 12-bit converter.
// Assumes the analog front end supplies a signed raw sample; the serial pins
// come asynchronously from an SPI mode 1 master and are synchronised here.
`timescale 1ns/100ps

module adcsp_core
	import adcsp_pkg::*;
#(
	parameter int                RAW_W       = 16,
	parameter int                TIMEOUT_LEN = TIMEOUT_CYC,
	parameter logic [CONV_W-1:0] CONV_CYC [8] = '{
		CONV_W'(SYS_CLK_HZ / SPS_R0), CONV_W'(SYS_CLK_HZ / SPS_R1),
		CONV_W'(SYS_CLK_HZ / SPS_R2), CONV_W'(SYS_CLK_HZ / SPS_R3),
		CONV_W'(SYS_CLK_HZ / SPS_R4), CONV_W'(SYS_CLK_HZ / SPS_R5),
		CONV_W'(SYS_CLK_HZ / SPS_R6), CONV_W'(SYS_CLK_HZ / SPS_R6)}
)
(
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    srst,
	// Serial pins
	input  wire logic                    cs_n,
	input  wire logic                    sclk,
	input  wire logic                    din,
	output logic                         data_out_ready_pin_o,
	output logic                         data_out_ready_pin_oe,
	output logic                         data_out_pullup_en,
	// Analog front end
	input  wire logic signed [RAW_W-1:0] afe_sample,
	output logic                         afe_power_on,
	output logic [FIELD3_W-1:0]          afe_mux,
	output logic [FIELD3_W-1:0]          afe_gain,
	output logic [FIELD3_W-1:0]          afe_rate,
	output logic                         afe_temp_mode,
	// Status
	output logic [WORD_W-1:0]            conv_result,
	output logic [WORD_W-1:0]            config_word,
	output logic                         conv_busy
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic                 sclk_s1_q;
	logic                 sclk_s2_q;
	logic                 sclk_s3_q;
	logic                 cs_s1_q;
	logic                 cs_s2_q;
	logic                 din_s1_q;
	logic                 din_s2_q;

	// Only the second stage feeds logic; the third stage of SCLK is its
	// edge history for the rise and fall detectors
	always_ff @(posedge sys_clk)
	begin
		sclk_s1_q <= sclk;
		sclk_s2_q <= sclk_s1_q;
		sclk_s3_q <= sclk_s2_q;
		cs_s1_q   <= cs_n;
		cs_s2_q   <= cs_s1_q;
		din_s1_q  <= din;
		din_s2_q  <= din_s1_q;
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	adcsp_conv_e          state_q;
	adcsp_conv_e          state_d;
	logic [CONV_W-1:0]    conv_cnt_q;
	logic [CONV_W-1:0]    conv_cnt_d;
	logic [WORD_W-1:0]    result_q;
	logic [WORD_W-1:0]    cfg_q;
	logic                 new_data_q;
	logic [CNT_W-1:0]     bit_cnt_q;
	logic                 started_q;
	logic [WORD_W-1:0]    lock_q;
	logic [WORD_W-1:0]    rx_q;
	logic                 dout_q;
	logic                 pin_q;
	logic [TO_W-1:0]      to_cnt_q;

	// ------------------------------------------------------------------
	// Serial edge and reset decode
	// ------------------------------------------------------------------
	// Edge detection; the timeout only holds while SCLK is low, so the
	// first rise after a long idle is not masked and starts a new cycle
	wire                  sel_n       = cs_s2_q;
	wire                  to_full     = (to_cnt_q == TO_W'(TIMEOUT_LEN));
	wire                  timeout_hit = to_full & ~sclk_s2_q;
	wire                  port_rst    = sel_n | timeout_hit;
	wire                  sclk_rise   = sclk_s2_q & ~sclk_s3_q & ~port_rst;
	wire                  sclk_fall   = ~sclk_s2_q & sclk_s3_q & ~port_rst;

	// Word framing
	wire                  word_start  = sclk_rise & (bit_cnt_q == '0);
	wire                  cycle_end   = bit_cnt_q == CNT_W'(CYCLE_BITS - 1);
	wire                  word_end    = sclk_fall & (&bit_cnt_q[3:0]);

	// Receive decode
	wire [WORD_W-1:0]     rx_word     = {rx_q[WORD_W-2:0], din_s2_q};
	wire [1:0]            rx_nop      = rx_word[CFG_NOP_LSB +: 2];
	wire                  cfg_wr      = word_end & (rx_nop == NOP_VALID);
	wire                  ss_req      = cfg_wr & rx_word[CFG_SS_BIT];

	// Transmit select
	wire [3:0]            out_idx     = ~bit_cnt_q[3:0];
	wire                  in_cfg_half = bit_cnt_q >= CNT_W'(WORD_W);
	wire                  out_bit     = in_cfg_half ? cfg_q[out_idx]
	                                                : lock_q[out_idx];
	// Start bit reads back 0, reserved bit reads back 1
	wire [WORD_W-1:0]     cfg_new     = {SS_READ,
	                                     rx_word[WORD_W-2:1],
	                                     RSV_READ};

	// ------------------------------------------------------------------
	// Conversion result clipping
	// ------------------------------------------------------------------
	// Sample fits when its upper bits all equal the sign
	wire [RAW_W-RES_W:0]  raw_hi      = afe_sample[RAW_W-1:RES_W-1];
	wire                  raw_fits    = (&raw_hi) | ~(|raw_hi);
	wire [RES_W-1:0]      res_clip    = raw_fits ? afe_sample[RES_W-1:0]
	                                  : (afe_sample[RAW_W-1] ? CLIP_NEG
	                                                         : CLIP_POS);
	wire [WORD_W-1:0]     res_word    = {res_clip, RES_PAD};

	// ------------------------------------------------------------------
	// Conversion timing decode
	// ------------------------------------------------------------------
	wire                  mode_single = cfg_q[CFG_MODE_BIT];
	wire [FIELD3_W-1:0]   rate_code   = cfg_q[CFG_DR_LSB +: FIELD3_W];
	wire [CONV_W-1:0]     conv_len    = CONV_CYC[rate_code];
	wire                  conv_done   = (state_q != ST_DOWN)
	                                  & (conv_cnt_q == conv_len - 1'b1);
	wire                  rdy_lead    = (state_q == ST_CONT)
	                                  & (conv_cnt_q == conv_len
	                                     - CONV_W'(RDY_LEAD_CYC));

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		state_d    = state_q;
		conv_cnt_d = conv_cnt_q + 1'b1;
		case (state_q)
			ST_DOWN:
			begin
				conv_cnt_d = '0;
				if (ss_req)
					state_d = ST_SINGLE;
				else if (!mode_single)
					state_d = ST_CONT;
			end
			ST_SINGLE:
			begin
				if (conv_done)
				begin
					conv_cnt_d = '0;
					state_d    = mode_single ? ST_DOWN : ST_CONT;
				end
			end
			ST_CONT:
			// A mode 1 write aborts the running conversion
			begin
				if (mode_single)
				begin
					conv_cnt_d = '0;
					state_d    = ST_DOWN;
				end
				else if (conv_done)
					conv_cnt_d = '0;
			end
			default:
			begin
				conv_cnt_d = '0;
				state_d    = ST_DOWN;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_q    <= ST_DOWN;
			conv_cnt_q <= '0;
		end
		else
		begin
			state_q    <= state_d;
			conv_cnt_q <= conv_cnt_d;
		end
	end

	// ------------------------------------------------------------------
	// Conversion register and configuration register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			result_q <= RESULT_RST;
			cfg_q    <= CFG_RST;
		end
		else
		begin
			if (conv_done)
				result_q <= res_word;
			if (cfg_wr)
				cfg_q <= cfg_new;
		end
	end

	// New data flag: a completion wins over a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			new_data_q <= 1'b0;
		else if (conv_done)
			new_data_q <= 1'b1;
		else if (word_start | rdy_lead)
			new_data_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Serial port: timeout
	// ------------------------------------------------------------------
	// Counts cycles with CS low and SCLK low, then saturates
	always_ff @(posedge sys_clk)
	begin
		if (srst | sel_n | sclk_s2_q)
			to_cnt_q <= '0;
		else if (!to_full)
			to_cnt_q <= to_cnt_q + 1'b1;
	end

	// ------------------------------------------------------------------
	// Serial port: bit counter and receive shifter
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst | port_rst)
		begin
			bit_cnt_q <= '0;
			rx_q      <= '0;
		end
		else if (sclk_fall)
		begin
			rx_q      <= rx_word;
			bit_cnt_q <= cycle_end ? '0 : bit_cnt_q + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Serial port: transmit path
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst | port_rst)
			started_q <= 1'b0;
		else if (sclk_rise)
			started_q <= 1'b1;
		else if (sclk_fall & cycle_end)
			started_q <= 1'b0;
	end

	// First rise loads the locked word and presents its MSB together
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			lock_q <= RESULT_RST;
			dout_q <= 1'b0;
		end
		else if (word_start)
		begin
			lock_q <= result_q;
			dout_q <= result_q[WORD_W-1];
		end
		else if (sclk_rise)
			dout_q <= out_bit;
	end

	// ------------------------------------------------------------------
	// Output pin
	// ------------------------------------------------------------------
	// Between transfers the pin shows the ready level, low for new data
	wire                  ready_lvl = ~new_data_q;
	wire                  pin_d     = started_q ? dout_q : ready_lvl;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pin_q <= 1'b1;
		else
			pin_q <= pin_d;
	end

	assign data_out_ready_pin_o  = pin_q;
	// Enable drops in reset so the pin never shows a stale level
	assign data_out_ready_pin_oe = ~sel_n & ~srst;
	assign data_out_pullup_en    = sel_n & cfg_q[CFG_PU_BIT];

	// ------------------------------------------------------------------
	// Front end and status
	// ------------------------------------------------------------------
	assign afe_power_on  = state_q != ST_DOWN;
	assign afe_mux       = cfg_q[CFG_MUX_LSB +: FIELD3_W];
	assign afe_gain      = cfg_q[CFG_PGA_LSB +: FIELD3_W];
	assign afe_rate      = rate_code;
	assign afe_temp_mode = cfg_q[CFG_TS_BIT];
	assign conv_result   = result_q;
	assign config_word   = cfg_q;
	assign conv_busy     = state_q != ST_DOWN;

endmodule

// ==== tb/adcsp_assertions.sv ====
// Concurrent checks on the ports of the converter mode control and port.
// Assumes it is bound to adcsp_core and sees that module's ports only.
`timescale 1ns/100ps
module adcsp_assertions
	import adcsp_pkg::*;
#(
	parameter logic [CONV_W-1:0] CONV_CYC [8] = '{default: 18'h258}
)
(
	// Clock and reset
	input wire logic                sys_clk,
	input wire logic                srst,
	// Serial side
	input wire logic                cs_n,
	input wire logic                data_out_ready_pin_oe,
	input wire logic                data_out_pullup_en,
	// Status
	input wire logic [FIELD3_W-1:0] afe_rate,
	input wire logic [WORD_W-1:0]   conv_result,
	input wire logic [WORD_W-1:0]   config_word,
	input wire logic                conv_busy
);
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	// Length of the current run of busy cycles
	logic [CONV_W-1:0] run_q;
	logic [CONV_W-1:0] run_d;
	assign run_d = conv_busy ? run_q + 18'h1 : 18'h0;
	always_ff @(posedge sys_clk)
		run_q <= run_d;
	sequence desel_s;
		cs_n [*5];
	endsequence
	sequence sel_s;
		!cs_n [*6];
	endsequence
	reset_default_a: assert property (
		$fell(srst) |-> config_word == CFG_RST && !conv_busy
		&& conv_result == RESULT_RST) else $error("reset state wrong");
	pin_release_a: assert property (
		desel_s |-> !data_out_ready_pin_oe) else $error("pin not released");
	pin_drive_a: assert property (
		sel_s |-> data_out_ready_pin_oe) else $error("pin not driven");
	pullup_follow_a: assert property (
		desel_s |-> data_out_pullup_en == config_word[CFG_PU_BIT])
		else $error("pullup wrong while deselected");
	pullup_off_a: assert property (
		sel_s |-> !data_out_pullup_en) else $error("pullup while selected");
	result_pad_a: assert property (
		$changed(conv_result) |-> conv_result[3:0] == RES_PAD)
		else $error("result low nibble not zero");
	fixed_bits_a: assert property (
		config_word[CFG_SS_BIT] == SS_READ && config_word[0] == RSV_READ)
		else $error("fixed config bits wrong");
	cont_run_a: assert property (
		!config_word[CFG_MODE_BIT] && conv_busy |=>
		conv_busy || config_word[CFG_MODE_BIT]) else $error("run stopped");
	cont_start_a: assert property (
		$fell(config_word[CFG_MODE_BIT]) |-> ##[0:2] conv_busy)
		else $error("continuous run not started");
	mode_stop_a: assert property (
		$rose(config_word[CFG_MODE_BIT]) |-> ##[0:2] !conv_busy)
		else $error("continuous run not stopped");
	single_len_a: assert property (
		$fell(conv_busy) && $past(config_word[CFG_MODE_BIT], 3) |->
		run_q + 2 >= CONV_CYC[afe_rate] && run_q <= CONV_CYC[afe_rate] + 2)
		else $error("single conversion length wrong");
endmodule

bind adcsp_core adcsp_assertions #(.CONV_CYC(CONV_CYC)) u_chk (
	.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .afe_rate(afe_rate),
	.data_out_ready_pin_oe(data_out_ready_pin_oe), .conv_busy(conv_busy),
	.data_out_pullup_en(data_out_pullup_en), .conv_result(conv_result),
	.config_word(config_word));

// ==== tb/adcsp_spi_master.sv ====
// SPI mode 1 master model for the converter's serial pins.
// Assumes the bench resolves the shared data pin onto pin.
`timescale 1ns/100ps
module adcsp_spi_master (
	// Serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic pin
);
	initial
	begin
		cs_n = 1'h1;
		sclk = 1'h0;
		din  = 1'h0;
	end
	task automatic sel();
		cs_n = 1'h0;
		#1007;
	endtask
	task automatic desel();
		cs_n = 1'h1;
		#1000;
	endtask
	// Launch on rise, sample just before the next rise
	task automatic xfer(input int n, input logic [31:0] tx,
		output logic [31:0] rx);
		rx = 32'h0;
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk = 1'h1;
			din  = tx[i];
			#200 sclk = 1'h0;
			#200 rx = {rx[30:0], pin};
		end
		#50 din = ~din;
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the converter mode control and serial port.
// Assumes adcsp_core, the SPI master model and the bound checker.
`timescale 1ns/100ps
module testbench;
	import adcsp_pkg::*;
	logic               sys_clk;
	logic               srst;
	logic               cs_n;
	logic               sclk;
	logic               din;
	logic               pin_o;
	logic               pin_oe;
	logic               pu_en;
	logic               pin_last;
	logic               pin_w;
	logic signed [15:0] afe_sample;
	logic signed [15:0] raw;
	logic [2:0]         afe_mux;
	logic [2:0]         afe_gain;
	logic [2:0]         afe_rate;
	logic               afe_temp_mode;
	logic               busy;
	logic               pwr;
	logic [15:0]        conv_result;
	logic [15:0]        config_word;
	logic [15:0]        w;
	logic [15:0]        last;
	logic [15:0]        corner [4] = '{16'h07FF, 16'hF800, 16'h0800, 16'hF7FF};
	logic [31:0]        r;
	logic [31:0]        rx;
	logic [1:0]         bad;
	int                 error_cnt = 0;
	int                 comparisons = 0;
	int                 cyc = 0;
	adcsp_core #(.TIMEOUT_LEN(200), .CONV_CYC('{default: 18'h258})) u_dut (
		.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .din(din),
		.data_out_ready_pin_o(pin_o), .data_out_ready_pin_oe(pin_oe),
		.data_out_pullup_en(pu_en), .afe_sample(afe_sample),
		.afe_power_on(pwr), .afe_mux(afe_mux), .afe_gain(afe_gain),
		.afe_rate(afe_rate), .afe_temp_mode(afe_temp_mode), .conv_busy(busy),
		.conv_result(conv_result), .config_word(config_word));
	adcsp_spi_master u_m (.cs_n(cs_n), .sclk(sclk), .din(din), .pin(pin_w));
	// Released pin: pulled up, or floating shown as the inverse of last value
	assign pin_w = pin_oe ? pin_o : (pu_en ? 1'h1 : ~pin_last);
	always @(posedge sys_clk)
		if (pin_oe)
			pin_last <= pin_o;
	initial
	begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	function automatic logic [15:0] clip(input logic signed [15:0] v);
		if (v > 2047)
			return 16'h7FF0;
		if (v < -2048)
			return 16'h8000;
		return {v[11:0], 4'h0};
	endfunction
	function automatic logic [15:0] cfgx(input logic [15:0] v);
		return {1'h0, v[14:1], 1'h1};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input int n, input logic [31:0] tx, input logic pe,
		output logic [31:0] rq);
		u_m.sel();
		if (pe !== 1'hx)
			chk("ready pin", pe, pin_w);
		u_m.xfer(n, tx, rq);
		u_m.desel();
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	initial
	begin
		srst = 1'h1;
		afe_sample = 16'h0000;
		pin_last = 1'h0;
		last = 16'h0000;
		void'($urandom(1));
		repeat (6) @(posedge sys_clk);
		srst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		chk("config", CFG_RST, config_word);
		chk("result", RESULT_RST, conv_result);
		chk("busy", 1'h0, busy);
		chk("pullup", 1'h1, pu_en);
		chk("pin enable", 1'h0, pin_oe);
		for (int i = 0; i < 6; i++)
		begin
			r = $urandom;
			@(posedge sys_clk);
			raw = (i < 4) ? corner[i] : r[15:0];
			afe_sample <= raw;
			w = {1'h1, r[30:25], 1'h1, r[23:20], 3'h5, r[16]};
			rd(32, {w, w}, 1'h1, rx);
			chk("echo", cfgx(w), rx[15:0]);
			chk("old result", last, rx[31:16]);
			chk("config", cfgx(w), config_word);
			chk("fields", {w[14:9], w[7:4]},
				{afe_mux, afe_gain, afe_rate, afe_temp_mode});
			chk("busy", 1'h1, busy);
			chk("power", 1'h1, pwr);
			for (int n = 0; n < 3000 && busy !== 1'h0; n++)
				@(posedge sys_clk);
			repeat (20) @(posedge sys_clk);
			chk("single shot", 1'h0, busy);
			chk("powered down", 1'h0, pwr);
			last = clip(raw);
			chk("result", last, conv_result);
			rd(16, 32'h0, 1'h0, rx);
			chk("read", last, rx[15:0]);
			bad = (i % 3 == 1) ? 2'h3 : 2'(i % 3);
			rd(16, {r[15:3], bad, r[0]}, 1'h1, rx);
			chk("repeat", last, rx[15:0]);
			chk("config kept", cfgx(w), config_word);
		end
		rd(32, {2{16'h0483}}, 1'h1, rx);
		chk("pullup", 1'h0, pu_en);
		r = $urandom;
		@(posedge sys_clk);
		afe_sample <= r[15:0];
		repeat (700) @(posedge sys_clk);
		chk("continuous", clip(r[15:0]), conv_result);
		chk("busy", 1'h1, busy);
		u_m.sel();
		u_m.xfer(5, 32'h1F, rx);
		repeat (300) @(posedge sys_clk);
		u_m.xfer(32, {2{16'h058B}}, rx);
		u_m.desel();
		chk("after timeout", cfgx(16'h058B), rx[15:0]);
		chk("locked", clip(r[15:0]), rx[31:16]);
		chk("stopped", 1'h0, busy);
		end_sim();
	end
endmodule
